// File: rtl/gpks_pkg.sv
/*
 * Shared constants and types for the GPIO ports and keypad scanner.
 * Assumes a byte-wide register port and a 250 MHz core clock.
 */
package gpks_pkg;

  // ****************************************************************
  // Register map
  // ****************************************************************
  localparam logic [7:0] OFS_PORT_A = 8'h00;
  localparam logic [7:0] OFS_PORT_B = 8'h04;
  localparam logic [7:0] OFS_PORT_C = 8'h08;
  localparam logic [7:0] OFS_PORT_D = 8'h0C;
  localparam logic [1:0] SUB_DATA = 2'h0;
  localparam logic [1:0] SUB_SEL = 2'h1;
  localparam logic [1:0] SUB_DIR = 2'h2;
  localparam logic [7:0] OFS_KP_DIR = 8'h10;
  localparam logic [7:0] OFS_KP_STROBE = 8'h11;
  localparam logic [7:0] OFS_KP_RETURN = 8'h12;
  localparam logic [7:0] OFS_SCAN_CTRL = 8'h13;
  localparam logic [7:0] OFS_SCAN_STAT = 8'h14;

  // ****************************************************************
  // Fields and reset values
  // ****************************************************************
  localparam int SCAN_EN_BIT = 0;
  localparam int TICK_INT_BIT = 1;
  localparam int KEY_FLAG_BIT = 0;
  localparam int STRB_IDX_LSB = 4;
  localparam logic [7:0] DATA_RST = 8'h00;
  localparam logic [7:0] SEL_RST = 8'h00;
  localparam logic [7:0] DIR_RST = 8'hFF;
  localparam logic [7:0] KP_DIR_RST = 8'hFF;
  localparam logic [7:0] KP_STROBE_RST = 8'hFF;
  localparam logic [1:0] SCAN_CTRL_RST = 2'h0;
  localparam logic [7:0] ALT_OUT_C = 8'h3F;
  localparam logic [7:0] ALT_IN_C = 8'h40;
  localparam logic [7:0] ALT_IN_A = 8'h01;
  localparam logic [7:0] ALT_OUT_D = 8'h07;
  localparam logic [7:0] MASK_NONE = 8'h00;

  // ****************************************************************
  // Timing
  // ****************************************************************
  localparam int CLK_MHZ = 250;
  localparam int FRAME_TIME_US = 4600;
  localparam int FRAME_CYCLES = FRAME_TIME_US * CLK_MHZ;

  typedef struct packed {
    logic [7:0] data;
    logic [7:0] sel;
    logic [7:0] dir;
  } gpks_port_cfg_type;

  typedef struct packed {
    logic [2:0] chip_select;
    logic trace_tx;
    logic annunciator_pwm;
    logic card_reset_out;
    logic card_read_write;
    logic card_power_on;
    logic card_voltage_select;
  } gpks_alt_type;

endpackage

// File: rtl/gpks_port.sv
/*
 * One GPIO port slice: pin synchroniser, function select and direction.
 * Assumes the configuration comes from registers on the same clock.
 */
`timescale 1ns/1ps
module gpks_port #(
  parameter int W = 8,
  parameter logic [7:0] ALT_OUT_MASK = 8'h00,
  parameter logic [7:0] ALT_IN_MASK = 8'h00
) (
  // Clock and reset
  input wire logic core_clk_i,
  input wire logic rst_n_i,
  // Configuration
  input wire gpks_pkg::gpks_port_cfg_type cfg_i,
  input wire logic [W-1:0] alt_out_i,
  // Pins
  input wire logic [W-1:0] pin_i,
  output logic [W-1:0] pin_out_o,
  output logic [W-1:0] pin_oe_o,
  output logic [W-1:0] pin_level_o
);

  logic [W-1:0] sync1_reg;
  logic [W-1:0] out_next;
  logic [W-1:0] oe_next;

  always_ff @(posedge core_clk_i) begin
    if (!rst_n_i) begin
      sync1_reg <= '0;
      pin_level_o <= '0;
    end else begin
      sync1_reg <= pin_i;
      pin_level_o <= sync1_reg;
    end
  end

  always_comb begin
    for (int i = 0; i < W; i++) begin
      if (cfg_i.sel[i] && ALT_OUT_MASK[i]) begin
        out_next[i] = alt_out_i[i];
        oe_next[i] = 1'b1;
      end else if (cfg_i.sel[i] && ALT_IN_MASK[i]) begin
        out_next[i] = 1'b0;
        oe_next[i] = 1'b0;
      end else begin
        out_next[i] = cfg_i.data[i];
        oe_next[i] = ~cfg_i.dir[i];
      end
    end
  end

  always_ff @(posedge core_clk_i) begin
    if (!rst_n_i) begin
      pin_out_o <= '0;
      pin_oe_o <= '0;
    end else begin
      pin_out_o <= out_next;
      pin_oe_o <= oe_next;
    end
  end

endmodule

// File: rtl/gpks_top.sv
/*
 * GPIO ports A to D plus keypad strobe scanner with register port.
 * Assumes a frame tick on the core clock or the internal divider.
 */
`timescale 1ns/1ps
// Summary of operation
// - 27 pins: ports A, B, C of eight, D of three.
// - each port has data, function select and direction registers.
// - every port B input pin has its own interrupt request.
// - port B requests are combinational, valid without clock.
// - register bit n belongs to pin n of its port.
// - data write sets driven levels; read returns pin levels.
// - select 1 routes alternate function, 0 keeps general purpose.
// - alternate functions: A0 return 4, C0-C6 card/pwm/trace, D chip selects.
// - direction 0 is output, 1 is input.
// - eight strobes, four returns, A0 adds a fifth return.
// - unused strobes serve as general purpose pins.
// - each frame one strobe low, all others high.
// - low return during scan raises key interrupt.
// - active strobe steps through all eight, one per frame.
// - strobe direction bit n for strobe n, 0 output.
// - strobe direction register resets to FF.
// - strobe level register drives output strobes bit by bit while scanning is off.
// - return register reads current return levels, bit n line n.
module gpks_top #(
  parameter int FRAME_CYCLES = gpks_pkg::FRAME_CYCLES
) (
  // Clock and reset
  input wire logic core_clk_i,
  input wire logic rst_n_i,
  // Register port
  input wire logic [7:0] reg_addr_i,
  input wire logic [7:0] reg_wdata_i,
  input wire logic reg_wr_i,
  input wire logic reg_rd_i,
  output logic [7:0] reg_rdata_o,
  // GPIO pins
  input wire logic [7:0] port_a_in_i,
  output logic [7:0] port_a_out_o,
  output logic [7:0] port_a_oe_o,
  input wire logic [7:0] port_b_in_i,
  output logic [7:0] port_b_out_o,
  output logic [7:0] port_b_oe_o,
  input wire logic [7:0] port_c_in_i,
  output logic [7:0] port_c_out_o,
  output logic [7:0] port_c_oe_o,
  input wire logic [2:0] port_d_in_i,
  output logic [2:0] port_d_out_o,
  output logic [2:0] port_d_oe_o,
  output logic [7:0] port_b_irq_o,
  // Alternate functions
  input wire gpks_pkg::gpks_alt_type alt_func_i,
  output logic trace_rx_o,
  // Keypad
  input wire logic [7:0] strobe_in_i,
  output logic [7:0] strobe_out_o,
  output logic [7:0] strobe_oe_o,
  input wire logic [3:0] keypad_return_i,
  output logic key_irq_o,
  // Frame timing
  input wire logic frame_tick_i
);

  // ****************************************************************
  // Registers
  // ****************************************************************
  gpks_pkg::gpks_port_cfg_type cfg_reg [4];
  logic [7:0] kp_dir_reg;
  logic [7:0] kp_strobe_reg;
  logic [1:0] scan_ctrl_reg;
  logic key_flag_reg;
  logic [2:0] strb_idx_reg;
  logic [31:0] div_cnt_reg;
  logic [7:0] lvl [4];
  logic [7:0] strb_sync1_reg;
  logic [7:0] strb_lvl_reg;
  logic [3:0] ret_sync1_reg;
  logic [3:0] ret_lvl_reg;
  logic [4:0] returns;
  logic frame_step;
  logic key_hit;
  logic is_port;
  logic [1:0] port_sel;
  logic [7:0] rdata_next;

  // address low bits pick register, bit n is pin n
  assign is_port = (reg_addr_i[7:4] == 4'h0) && (reg_addr_i[1:0] != 2'h3);
  assign port_sel = reg_addr_i[3:2];

  always_ff @(posedge core_clk_i) begin
    if (!rst_n_i) begin
      for (int p = 0; p < 4; p++) begin
        cfg_reg[p] <= '{gpks_pkg::DATA_RST, gpks_pkg::SEL_RST, gpks_pkg::DIR_RST};
      end
    end else if (reg_wr_i && is_port) begin
      if (reg_addr_i[1:0] == gpks_pkg::SUB_DATA) begin
        cfg_reg[port_sel].data <= reg_wdata_i;
      end else if (reg_addr_i[1:0] == gpks_pkg::SUB_SEL) begin
        cfg_reg[port_sel].sel <= reg_wdata_i;
      end else begin
        cfg_reg[port_sel].dir <= reg_wdata_i;
      end
    end
  end

  always_ff @(posedge core_clk_i) begin
    if (!rst_n_i) begin
      kp_dir_reg <= gpks_pkg::KP_DIR_RST;
      kp_strobe_reg <= gpks_pkg::KP_STROBE_RST;
      scan_ctrl_reg <= gpks_pkg::SCAN_CTRL_RST;
    end else if (reg_wr_i) begin
      if (reg_addr_i == gpks_pkg::OFS_KP_DIR) begin
        kp_dir_reg <= reg_wdata_i;
      end else if (reg_addr_i == gpks_pkg::OFS_KP_STROBE) begin
        kp_strobe_reg <= reg_wdata_i;
      end else if (reg_addr_i == gpks_pkg::OFS_SCAN_CTRL) begin
        scan_ctrl_reg <= reg_wdata_i[1:0];
      end
    end
  end

  // ****************************************************************
  // Port slices
  // ****************************************************************
  // four ports, 27 pins
  gpks_port #(.W(8), .ALT_OUT_MASK(gpks_pkg::MASK_NONE), .ALT_IN_MASK(gpks_pkg::ALT_IN_A))
    u_port_a (
    .core_clk_i(core_clk_i),
    .rst_n_i(rst_n_i),
    .cfg_i(cfg_reg[0]),
    .alt_out_i(8'h00),
    .pin_i(port_a_in_i),
    .pin_out_o(port_a_out_o),
    .pin_oe_o(port_a_oe_o),
    .pin_level_o(lvl[0])
  );

  gpks_port #(.W(8), .ALT_OUT_MASK(gpks_pkg::MASK_NONE), .ALT_IN_MASK(gpks_pkg::MASK_NONE))
    u_port_b (
    .core_clk_i(core_clk_i),
    .rst_n_i(rst_n_i),
    .cfg_i(cfg_reg[1]),
    .alt_out_i(8'h00),
    .pin_i(port_b_in_i),
    .pin_out_o(port_b_out_o),
    .pin_oe_o(port_b_oe_o),
    .pin_level_o(lvl[1])
  );

  // card, annunciator and trace functions on port C
  gpks_port #(.W(8), .ALT_OUT_MASK(gpks_pkg::ALT_OUT_C), .ALT_IN_MASK(gpks_pkg::ALT_IN_C))
    u_port_c (
    .core_clk_i(core_clk_i),
    .rst_n_i(rst_n_i),
    .cfg_i(cfg_reg[2]),
    .alt_out_i({2'h0, alt_func_i[5:0]}),
    .pin_i(port_c_in_i),
    .pin_out_o(port_c_out_o),
    .pin_oe_o(port_c_oe_o),
    .pin_level_o(lvl[2])
  );

  gpks_port #(.W(3), .ALT_OUT_MASK(gpks_pkg::ALT_OUT_D), .ALT_IN_MASK(gpks_pkg::MASK_NONE))
    u_port_d (
    .core_clk_i(core_clk_i),
    .rst_n_i(rst_n_i),
    .cfg_i(cfg_reg[3]),
    .alt_out_i(alt_func_i.chip_select),
    .pin_i(port_d_in_i),
    .pin_out_o(port_d_out_o),
    .pin_oe_o(port_d_oe_o),
    .pin_level_o(lvl[3][2:0])
  );
  assign lvl[3][7:3] = 5'h00;

  // one request per port B input pin
  // no flop in this path, so it works with the clock stopped
  assign port_b_irq_o = port_b_in_i & cfg_reg[1].dir;

  always_ff @(posedge core_clk_i) begin
    if (!rst_n_i) begin
      trace_rx_o <= 1'b1;
    end else begin
      trace_rx_o <= cfg_reg[2].sel[6] ? lvl[2][6] : 1'b1;
    end
  end

  // ****************************************************************
  // Keypad scan
  // ****************************************************************
  always_ff @(posedge core_clk_i) begin
    if (!rst_n_i) begin
      strb_sync1_reg <= 8'hFF;
      strb_lvl_reg <= 8'hFF;
      ret_sync1_reg <= 4'hF;
      ret_lvl_reg <= 4'hF;
    end else begin
      strb_sync1_reg <= strobe_in_i;
      strb_lvl_reg <= strb_sync1_reg;
      ret_sync1_reg <= keypad_return_i;
      ret_lvl_reg <= ret_sync1_reg;
    end
  end

  // fifth return from port A pin 0 when selected
  // returns used raw, no debounce filter
  assign returns = {cfg_reg[0].sel[0] ? lvl[0][0] : 1'b1, ret_lvl_reg};

  // Internal frame divider, used only when the scan control tick bit selects it
  always_ff @(posedge core_clk_i) begin
    if (!rst_n_i || !scan_ctrl_reg[gpks_pkg::TICK_INT_BIT]) begin
      div_cnt_reg <= 32'h0;
    end else if (div_cnt_reg == 32'(FRAME_CYCLES - 1)) begin
      div_cnt_reg <= 32'h0;
    end else begin
      div_cnt_reg <= div_cnt_reg + 32'h1;
    end
  end

  assign frame_step = scan_ctrl_reg[gpks_pkg::SCAN_EN_BIT] &&
    (scan_ctrl_reg[gpks_pkg::TICK_INT_BIT] ? (div_cnt_reg == 32'(FRAME_CYCLES - 1))
      : frame_tick_i);

  // one strobe per frame across eight
  // advance on tick, wrap 7 to 0
  always_ff @(posedge core_clk_i) begin
    if (!rst_n_i) begin
      strb_idx_reg <= 3'h0;
    end else if (frame_step) begin
      strb_idx_reg <= strb_idx_reg + 3'h1;
    end
  end

  // scanning drives one strobe low, others high
  // direction bit n for strobe n
  // input strobes act as plain GPIO
  always_ff @(posedge core_clk_i) begin
    if (!rst_n_i) begin
      strobe_out_o <= 8'hFF;
      strobe_oe_o <= 8'h00;
    end else begin
      strobe_oe_o <= ~kp_dir_reg;
      if (scan_ctrl_reg[gpks_pkg::SCAN_EN_BIT]) begin
        strobe_out_o <= ~(8'h01 << strb_idx_reg);
      end else begin
        strobe_out_o <= kp_strobe_reg;
      end
    end
  end

  // low return while active strobe drives low
  assign key_hit = scan_ctrl_reg[gpks_pkg::SCAN_EN_BIT] && strobe_oe_o[strb_idx_reg] &&
    !strobe_out_o[strb_idx_reg] && (returns != 5'h1F);

  // Set wins over a write-one clear in the same cycle
  always_ff @(posedge core_clk_i) begin
    if (!rst_n_i) begin
      key_flag_reg <= 1'b0;
      key_irq_o <= 1'b0;
    end else begin
      if (key_hit) begin
        key_flag_reg <= 1'b1;
      end else if (reg_wr_i && reg_addr_i == gpks_pkg::OFS_SCAN_STAT &&
                   reg_wdata_i[gpks_pkg::KEY_FLAG_BIT]) begin
        key_flag_reg <= 1'b0;
      end
      key_irq_o <= key_flag_reg;
    end
  end

  // ****************************************************************
  // Read path
  // ****************************************************************
  // data read returns pin levels
  always_comb begin
    rdata_next = 8'h00;
    if (!reg_rd_i) begin
      rdata_next = 8'h00;
    end else if (is_port && reg_addr_i[1:0] == gpks_pkg::SUB_DATA) begin
      rdata_next = lvl[port_sel];
    end else if (is_port && reg_addr_i[1:0] == gpks_pkg::SUB_SEL) begin
      rdata_next = cfg_reg[port_sel].sel;
    end else if (is_port) begin
      rdata_next = cfg_reg[port_sel].dir;
    end else if (reg_addr_i == gpks_pkg::OFS_KP_DIR) begin
      rdata_next = kp_dir_reg;
    end else if (reg_addr_i == gpks_pkg::OFS_KP_STROBE) begin
      rdata_next = strb_lvl_reg;
    end else if (reg_addr_i == gpks_pkg::OFS_KP_RETURN) begin
      rdata_next = {3'h0, returns};
    end else if (reg_addr_i == gpks_pkg::OFS_SCAN_CTRL) begin
      rdata_next = {6'h00, scan_ctrl_reg};
    end else if (reg_addr_i == gpks_pkg::OFS_SCAN_STAT) begin
      rdata_next = {1'b0, strb_idx_reg, 3'h0, key_flag_reg};
    end
  end

  always_ff @(posedge core_clk_i) begin
    if (!rst_n_i) begin
      reg_rdata_o <= 8'h00;
    end else begin
      reg_rdata_o <= rdata_next;
    end
  end

  // ****************************************************************
  // Assertions
  // ****************************************************************
  property p_one_low;
    @(posedge core_clk_i) disable iff (!rst_n_i)
    scan_ctrl_reg[0] |=> ($countones(~strobe_out_o) == 1);
  endproperty
  a_one_low: assert property (p_one_low) else $error("scan strobe not one-low");

  property p_step;
    @(posedge core_clk_i) disable iff (!rst_n_i)
    frame_step |=> strb_idx_reg == 3'($past(strb_idx_reg) + 3'h1);
  endproperty
  a_step: assert property (p_step) else $error("strobe index did not step");

  property p_wrap;
    @(posedge core_clk_i) disable iff (!rst_n_i)
    frame_step && strb_idx_reg == 3'h7 |=> strb_idx_reg == 3'h0;
  endproperty
  a_wrap: assert property (p_wrap) else $error("strobe index did not wrap");

  property p_key;
    @(posedge core_clk_i) disable iff (!rst_n_i)
    key_hit |=> key_flag_reg ##1 key_irq_o;
  endproperty
  a_key: assert property (p_key) else $error("key press not flagged");

  property p_dir_rst;
    @(posedge core_clk_i) !rst_n_i |=> kp_dir_reg == 8'hFF && strobe_oe_o == 8'h00;
  endproperty
  a_dir_rst: assert property (p_dir_rst) else $error("strobe direction reset wrong");

  property p_birq;
    @(posedge core_clk_i) disable iff (!rst_n_i)
    $stable(cfg_reg[1].dir) |-> port_b_irq_o == (port_b_in_i & ~port_b_oe_o);
  endproperty
  a_birq: assert property (p_birq) else $error("port B request mismatch");

  property p_gpio_out;
    @(posedge core_clk_i) disable iff (!rst_n_i)
    !cfg_reg[1].dir[2] |=> port_b_oe_o[2] && port_b_out_o[2] == $past(cfg_reg[1].data[2]);
  endproperty
  a_gpio_out: assert property (p_gpio_out) else $error("output pin not driven");

  property p_strobe_gpio;
    @(posedge core_clk_i) disable iff (!rst_n_i)
    !scan_ctrl_reg[0] |=> strobe_out_o == $past(kp_strobe_reg);
  endproperty
  a_strobe_gpio: assert property (p_strobe_gpio) else $error("strobe level wrong");

  property p_rd_idle;
    @(posedge core_clk_i) disable iff (!rst_n_i)
    !reg_rd_i |=> reg_rdata_o == 8'h00;
  endproperty
  a_rd_idle: assert property (p_rd_idle) else $error("read data outside slot");

  c_wrap: cover property (@(posedge core_clk_i) frame_step && strb_idx_reg == 3'h7);
  c_key: cover property (@(posedge core_clk_i) key_hit && !returns[4]);
  c_clear: cover property (@(posedge core_clk_i) key_flag_reg ##1 !key_flag_reg);

endmodule

// File: verification/gpks_periph_model.sv
/*
 * Handset-side model: peripherals on the port pins and the keypad matrix.
 * Assumes the bench sets the external pin levels and which key is closed.
 */
`timescale 1ns/1ps
module gpks_periph_model (
  // Port pins, D..A packed high to low
  input wire logic [26:0] pins_out_i,
  input wire logic [26:0] pins_oe_i,
  input wire logic [26:0] ext_i,
  output logic [26:0] pins_in_o,
  // Keypad matrix
  input wire logic [7:0] strobe_out_i,
  input wire logic [7:0] strobe_oe_i,
  output logic [7:0] strobe_in_o,
  input wire logic key_on_i,
  input wire logic [2:0] key_col_i,
  input wire logic [2:0] key_row_i,
  output logic [3:0] keypad_return_o
);
  logic key_low;

  // ****************************************************************
  // Matrix contacts
  // ****************************************************************
  // closed key pulls its row low while its column is driven low, no bounce
  assign key_low = key_on_i && strobe_oe_i[key_col_i] && !strobe_out_i[key_col_i];

  always_comb begin
    keypad_return_o = 4'hF;
    if (key_low && key_row_i < 3'h4) begin
      keypad_return_o[key_row_i[1:0]] = 1'b0;
    end
  end

  // undriven pins show the peripheral level
  always_comb begin
    pins_in_o = (pins_out_i & pins_oe_i) | (ext_i & ~pins_oe_i);
    if (key_low && key_row_i == 3'h4 && !pins_oe_i[0]) begin
      pins_in_o[0] = 1'b0;
    end
  end

  // Floating columns show the inverse, so a stale copy cannot pass
  assign strobe_in_o = (strobe_out_i & strobe_oe_i) | (~strobe_out_i & ~strobe_oe_i);
endmodule

// File: verification/tb_gpio_ports_keypad_scanner.sv
/*
 * Self-checking bench for the GPIO ports and keypad scanner.
 * Assumes gpks_pkg, gpks_top and gpks_periph_model are compiled first.
 */
`timescale 1ns/1ps
`define CHK(n, e, g) begin samples_checked++; if ((g) !== (e)) begin err_total++; \
  $display("CHECK FAILED %s exp %h got %h", n, e, g); end end
module tb_gpio_ports_keypad_scanner;
  localparam int FRAME = 16;
  logic core_clk_i = 1'b0;
  logic rst_n_i = 1'b0;
  logic [7:0] reg_addr_i = 8'h00;
  logic [7:0] reg_wdata_i = 8'h00;
  logic reg_wr_i = 1'b0;
  logic reg_rd_i = 1'b0;
  logic [7:0] reg_rdata_o, port_a_in_i, port_b_in_i, port_c_in_i, strobe_in_i;
  logic [7:0] port_a_out_o, port_a_oe_o, port_b_out_o, port_b_oe_o, port_b_irq_o;
  logic [7:0] port_c_out_o, port_c_oe_o, strobe_out_o, strobe_oe_o;
  logic [2:0] port_d_in_i, port_d_out_o, port_d_oe_o;
  logic [3:0] keypad_return_i;
  logic trace_rx_o, key_irq_o;
  logic frame_tick_i = 1'b0;
  gpks_pkg::gpks_alt_type alt_func_i = '0;
  logic [31:0] ext = 32'h0;
  logic [26:0] pin_lv;
  logic key_on = 1'b0;
  logic [2:0] key_col = 3'h0;
  logic [2:0] key_row = 3'h0;
  int err_total = 0;
  int samples_checked = 0;
  logic [7:0] mdl [int];
  wire [31:0] pout = {5'h00, port_d_out_o, port_c_out_o, port_b_out_o, port_a_out_o};
  wire [31:0] poe = {5'h00, port_d_oe_o, port_c_oe_o, port_b_oe_o, port_a_oe_o};

  assign {port_d_in_i, port_c_in_i, port_b_in_i, port_a_in_i} = pin_lv;
  always #2 core_clk_i = ~core_clk_i;

  gpks_top #(.FRAME_CYCLES(FRAME)) dut (
    .core_clk_i, .rst_n_i, .reg_addr_i, .reg_wdata_i, .reg_wr_i, .reg_rd_i, .reg_rdata_o,
    .port_a_in_i, .port_a_out_o, .port_a_oe_o, .port_b_in_i, .port_b_out_o, .port_b_oe_o,
    .port_c_in_i, .port_c_out_o, .port_c_oe_o, .port_d_in_i, .port_d_out_o, .port_d_oe_o,
    .port_b_irq_o, .alt_func_i, .trace_rx_o, .strobe_in_i, .strobe_out_o, .strobe_oe_o,
    .keypad_return_i, .key_irq_o, .frame_tick_i
  );

  gpks_periph_model periph (
    .pins_out_i(pout[26:0]), .pins_oe_i(poe[26:0]), .ext_i(ext[26:0]), .pins_in_o(pin_lv),
    .strobe_out_i(strobe_out_o), .strobe_oe_i(strobe_oe_o), .strobe_in_o(strobe_in_i),
    .key_on_i(key_on), .key_col_i(key_col), .key_row_i(key_row),
    .keypad_return_o(keypad_return_i)
  );

  // ****************************************************************
  // Bus and helper tasks
  // ****************************************************************
  task automatic settle(input int n);
    repeat (n) @(posedge core_clk_i);
    #1;
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge core_clk_i);
    reg_addr_i <= a;
    reg_wdata_i <= d;
    reg_wr_i <= 1'b1;
    @(posedge core_clk_i);
    reg_wr_i <= 1'b0;
    if (mdl.exists(a)) mdl[a] = d;
  endtask

  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(posedge core_clk_i);
    reg_addr_i <= a;
    reg_rd_i <= 1'b1;
    @(posedge core_clk_i);
    reg_rd_i <= 1'b0;
    #1;
    d = reg_rdata_o;
  endtask

  function automatic logic [7:0] ra(input int p, input logic [1:0] s);
    return 8'(p * 4) | {6'h00, s};
  endfunction

  // Port D has only three pins, so only the low three bits are compared
  task automatic chk_regs();
    logic [7:0] v;
    logic [7:0] m;
    foreach (mdl[k]) begin
      m = (k >= 12 && k < 16) ? 8'h07 : 8'hFF;
      rd(8'(k), v);
      `CHK("reg", mdl[k] & m, v & m)
    end
  endtask

  task automatic press(input int c, input int r, input logic [7:0] er, input logic ei);
    logic [7:0] v;
    @(posedge core_clk_i);
    key_col <= 3'(c);
    key_row <= 3'(r);
    key_on <= 1'b1;
    settle(4);
    rd(gpks_pkg::OFS_KP_RETURN, v);
    `CHK("returns", er, v)
    @(posedge core_clk_i);
    key_on <= 1'b0;
    settle(4);
    `CHK("key_irq", ei, key_irq_o)
    rd(gpks_pkg::OFS_SCAN_STAT, v);
    `CHK("key_flag", ei, v[0])
    wr(gpks_pkg::OFS_SCAN_STAT, 8'h01);
    settle(3);
    `CHK("key_clear", 1'b0, key_irq_o)
  endtask

  task automatic give_verdict();
    if (err_total == 0 && samples_checked > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask

  // ****************************************************************
  // Test sequence
  // ****************************************************************
  initial begin
    logic [7:0] v, w, m, dv, rv;
    void'($urandom(32'h08F1));
    for (int p = 0; p < 4; p++) begin
      mdl[ra(p, gpks_pkg::SUB_SEL)] = 8'h00;
      mdl[ra(p, gpks_pkg::SUB_DIR)] = 8'hFF;
    end
    mdl[gpks_pkg::OFS_KP_DIR] = 8'hFF;
    repeat (12) @(posedge core_clk_i);
    rst_n_i <= 1'b1;
    settle(1);
    `CHK("pin_oe", 32'h0, poe)
    `CHK("strobe_oe", 8'h00, strobe_oe_o)
    chk_regs();
    wr(8'h03, 8'hA5);
    rd(8'h03, v);
    `CHK("unmapped", 8'h00, v)
    for (int p = 0; p < 4; p++) begin
      m = (p == 3) ? 8'h07 : 8'hFF;
      dv = 8'($urandom) & m;
      rv = 8'($urandom) & m;
      @(posedge core_clk_i);
      ext <= 32'($urandom);
      wr(ra(p, gpks_pkg::SUB_DATA), dv);
      wr(ra(p, gpks_pkg::SUB_DIR), rv);
      settle(4);
      `CHK("pin_oe", ~rv & m, poe[p*8 +: 8] & m)
      `CHK("pin_out", dv & ~rv, pout[p*8 +: 8] & ~rv & m)
      rd(ra(p, gpks_pkg::SUB_DATA), v);
      `CHK("pin_in", ((dv & ~rv) | (ext[p*8 +: 8] & rv)) & m, v & m)
    end
    chk_regs();
    wr(ra(1, gpks_pkg::SUB_DIR), 8'hF0);
    settle(2);
    // Level changes one time unit apart, each checked #1 later with no clock wait
    repeat (4) begin
      v = 8'($urandom);
      ext[15:8] = v;
      #1;
      `CHK("irq", v & 8'hF0, port_b_irq_o)
    end
    wr(gpks_pkg::OFS_KP_DIR, 8'h0F);
    wr(gpks_pkg::OFS_KP_STROBE, 8'h5A);
    settle(2);
    `CHK("strobe_oe", 8'hF0, strobe_oe_o)
    `CHK("strobe_gpio", 8'h50, strobe_out_o & 8'hF0)
    rd(gpks_pkg::OFS_KP_STROBE, v);
    `CHK("strobe_in", 8'h55, v)
    wr(gpks_pkg::OFS_KP_DIR, 8'h00);
    wr(gpks_pkg::OFS_SCAN_CTRL, 8'h01);
    settle(2);
    for (int k = 0; k < 9; k++) begin
      `CHK("strobe", ~(8'h01 << (k % 8)), strobe_out_o)
      rd(gpks_pkg::OFS_SCAN_STAT, v);
      `CHK("index", 3'(k % 8), v[6:4])
      @(posedge core_clk_i);
      frame_tick_i <= 1'b1;
      @(posedge core_clk_i);
      frame_tick_i <= 1'b0;
      settle(2);
    end
    press(3, 2, 8'h1F, 1'b0);
    press(1, 2, 8'h1B, 1'b1);
    ext[0] = 1'b1;
    wr(ra(0, gpks_pkg::SUB_SEL), 8'h01);
    press(1, 4, 8'h0F, 1'b1);
    wr(ra(2, gpks_pkg::SUB_SEL), 8'h7F);
    wr(ra(3, gpks_pkg::SUB_SEL), 8'h07);
    repeat (3) begin
      @(posedge core_clk_i);
      alt_func_i <= 9'($urandom);
      ext[22] <= ~ext[22];
      settle(4);
      `CHK("alt_c", alt_func_i[5:0], port_c_out_o[5:0])
      `CHK("alt_d", alt_func_i[8:6], port_d_out_o)
      `CHK("alt_oe", 10'h3BF, {port_d_oe_o, port_c_oe_o[6:0]})
      `CHK("trace_rx", ext[22], trace_rx_o)
    end
    wr(gpks_pkg::OFS_SCAN_CTRL, 8'h03);
    rd(gpks_pkg::OFS_SCAN_STAT, w);
    repeat (FRAME - 2) @(posedge core_clk_i);
    rd(gpks_pkg::OFS_SCAN_STAT, v);
    `CHK("divider", 3'(w[6:4] + 3'h1), v[6:4])
    give_verdict();
  end

  // Whole run needs well under two thousand cycles
  initial begin
    repeat (20000) @(posedge core_clk_i);
    err_total++;
    give_verdict();
  end
endmodule
